//--- bench/fdcws_core_sva.sv
// Concurrent checks on the command sequencer ports.
`timescale 1ns/1ns
module fdcws_core_sva #(
   parameter int STEP_UNIT_CYC = 2
) (
   input wire logic                    mclk,
   input wire logic                    nrst,
   input wire logic                    ce,
   input wire logic                    host_wr,
   input wire logic [7:0]              host_wdata,
   input wire logic                    host_rd,
   input wire logic [7:0]              host_rdata,
   input wire logic                    result_ready,
   input wire logic                    cmd_busy,
   input wire logic                    exec_data_req,
   input wire logic                    fdc_interrupt,
   input wire fdcws_pkg::fdcws_spec_t  spec_cfg,
   input wire fdcws_pkg::fdcws_drive_t disk_drive,
   input wire logic                    disk_track0
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   // A command byte only counts when the sequencer is really idle.
   logic idle_cmd;
   assign idle_cmd = host_wr && ce && !cmd_busy && !result_ready
                     && !exec_data_req;

   logic [4:0] step_len;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         step_len <= 5'h00;
      else if (!disk_drive.step)
         step_len <= 5'h00;
      else if (ce && step_len != 5'h1f)
         step_len <= step_len + 5'h01;
   end

   a_version_reply: assert property (
      idle_cmd && host_wdata == 8'h10
      |-> ##3 (result_ready && host_rdata == 8'h90))
      else $error("version reply wrong");
   a_read_drop: assert property (
      ce && host_rd && result_ready |=> !result_ready)
      else $error("result ready held after read");
   a_ready_busy: assert property (
      result_ready |-> cmd_busy)
      else $error("result offered while idle");
   a_sense_report: assert property (
      idle_cmd && fdc_interrupt && host_wdata == 8'h08
      |-> ##3 (result_ready && host_rdata[5]))
      else $error("sense status lacks seek end");
   a_irq_clear: assert property (
      idle_cmd && fdc_interrupt && host_wdata == 8'h08
      |-> ##[1:8] !fdc_interrupt)
      else $error("interrupt not cleared by sense");
   a_step_width: assert property (
      $fell(disk_drive.step) |-> step_len == 5'h0a)
      else $error("step pulse width wrong");
   a_strobe_cause: assert property (
      disk_drive.wr_strobe
      |-> $past(host_wr) && disk_drive.wr_byte == $past(host_wdata))
      else $error("drive write without host byte");
   a_spec_cause: assert property (
      !$stable(spec_cfg) |-> $past(host_wr, 2))
      else $error("timing setup changed by itself");
   a_exec_result: assert property (
      exec_data_req |-> !result_ready)
      else $error("result during data phase");

   c_version: cover property (idle_cmd && host_wdata == 8'h10);
   c_step: cover property ($rose(disk_drive.step));
   c_irq: cover property ($fell(fdc_interrupt));
endmodule

bind fdcws_core fdcws_core_sva #(.STEP_UNIT_CYC(STEP_UNIT_CYC)) i_sva (
   .mclk(mclk), .nrst(nrst), .ce(ce), .host_wr(host_wr),
   .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
   .result_ready(result_ready), .cmd_busy(cmd_busy),
   .exec_data_req(exec_data_req), .fdc_interrupt(fdc_interrupt),
   .spec_cfg(spec_cfg), .disk_drive(disk_drive),
   .disk_track0(disk_track0));

//--- bench/fdcws_core_tb.sv
// Self-checking bench for the write, format and seek command sequencer.
`timescale 1ns/1ns
module fdcws_core_tb;
   logic                    mclk;
   logic                    nrst;
   logic                    ce;
   logic                    host_wr;
   logic [7:0]              host_wdata;
   logic                    host_rd;
   logic [7:0]              host_rdata;
   logic                    result_ready;
   logic                    cmd_busy;
   logic                    exec_data_req;
   logic                    fdc_interrupt;
   fdcws_pkg::fdcws_spec_t  spec_cfg;
   fdcws_pkg::fdcws_drive_t disk_drive;
   logic                    disk_track0;
   int                      mismatches;
   int                      tests_run;

   // ****************************************************************
   // Design and drive
   // ****************************************************************
   // A short step unit keeps seek runs to well under a hundred cycles.
   fdcws_core #(.STEP_UNIT_CYC(2)) i_dut (
      .mclk(mclk), .nrst(nrst), .ce(ce), .host_wr(host_wr),
      .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
      .result_ready(result_ready), .cmd_busy(cmd_busy),
      .exec_data_req(exec_data_req), .fdc_interrupt(fdc_interrupt),
      .spec_cfg(spec_cfg), .disk_drive(disk_drive),
      .disk_track0(disk_track0));
   fdcws_drive_model i_drv (.mclk(mclk), .drv(disk_drive),
                            .track0(disk_track0));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      @(negedge mclk);
      while (s !== 1'b1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      if (n == 3000) begin
         mismatches++;
         $display("ERROR %0t wait timed out", $time);
      end
   endtask

   task automatic put(input logic [7:0] b);
      @(posedge mclk);
      host_wr <= 1'b1;
      host_wdata <= b;
      @(posedge mclk);
      host_wr <= 1'b0;
   endtask

   task automatic get(input logic [7:0] exp);
      wait_hi(result_ready);
      chk(host_rdata, exp);
      @(posedge mclk);
      host_rd <= 1'b1;
      @(posedge mclk);
      host_rd <= 1'b0;
      #1 chk(result_ready, 1'b0);
   endtask

   task automatic t_version;
      put(8'h10);
      wait_hi(result_ready);
      @(posedge mclk);
      ce <= 1'b0;
      host_rd <= 1'b1;
      @(posedge mclk);
      ce <= 1'b1;
      host_rd <= 1'b0;
      #1 chk(result_ready, 1'b1);
      get(8'h90);
      $display("version test done");
   endtask

   task automatic t_specify;
      put(8'h03);
      put(8'hf3);
      put(8'h0b);
      repeat (3) @(posedge mclk);
      #1 chk(spec_cfg, 16'hf30b);
      chk(cmd_busy, 1'b0);
      put(8'h08);
      get(8'h80);
      $display("specify test done");
   endtask

   task automatic t_move(input logic [7:0] op, input logic [7:0] drv,
                         input logic [7:0] cyl, input logic [7:0] status);
      put(op);
      put(drv);
      if (op == 8'h0f) put(cyl);
      wait_hi(fdc_interrupt);
      chk(i_drv.cyl, cyl);
      chk(disk_drive.drive_select, drv[1:0]);
      chk(disk_drive.head_side_select, op == 8'h0f && drv[2]);
      put(8'h08);
      get(status);
      get(cyl);
      chk(fdc_interrupt, 1'b0);
      $display("head move test done");
   endtask

   task automatic t_write(input logic [7:0] op, input logic del);
      logic [7:0] prm [8];
      logic [7:0] res [7];
      prm = '{8'h05, 8'h02, 8'h01, 8'h03, 8'h00, 8'h04, 8'h1b, 8'h04};
      res = '{8'h05, 8'h00, 8'h00, 8'h02, 8'h01, 8'h05, 8'h00};
      if (op[7]) begin
         res[3] = 8'h03;
         res[5] = 8'h01;
      end
      put(op);
      foreach (prm[i]) put(prm[i]);
      for (int k = 0; k < 8; k++) begin
         wait_hi(exec_data_req);
         chk(disk_drive.deleted_mark, del);
         put(8'ha0 + k[7:0]);
         #1 chk({disk_drive.wr_strobe, disk_drive.wr_byte},
                {1'b1, 8'ha0 + k[7:0]});
      end
      foreach (res[i]) get(res[i]);
      $display("write test done");
   endtask

   task automatic t_format;
      logic [7:0] prm [5];
      logic [7:0] ids [8];
      prm = '{8'h05, 8'h02, 8'h02, 8'h1b, 8'he5};
      ids = '{8'h01, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00, 8'h02, 8'h02};
      put(8'h4d);
      foreach (prm[i]) put(prm[i]);
      foreach (ids[i]) begin
         wait_hi(exec_data_req);
         put(ids[i]);
      end
      get(8'h05);
      for (int k = 0; k < 6; k++) get(8'h00);
      $display("format test done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      #(100 * 40000);
      mismatches++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test;
   end

   initial begin
      mismatches = 0;
      tests_run = 0;
      nrst = 1'b0;
      ce = 1'b1;
      host_wr = 1'b0;
      host_wdata = 8'h00;
      host_rd = 1'b0;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      t_version;
      t_specify;
      t_move(8'h07, 8'h02, 8'h00, 8'h22);
      t_move(8'h0f, 8'h05, 8'h05, 8'h25);
      t_write(8'h45, 1'b0);
      t_write(8'h09, 1'b1);
      t_write(8'hc5, 1'b0);
      t_format;
      end_of_test;
   end
endmodule

//--- bench/fdcws_drive_model.sv
// Behavioural disk drive that follows the head stepping lines.
`timescale 1ns/1ns
module fdcws_drive_model #(
   parameter int START_CYL = 3
) (
   input  wire logic                    mclk,
   input  wire fdcws_pkg::fdcws_drive_t drv,
   output logic                         track0
);
   logic [7:0] cyl;
   logic       step_q;

   initial begin
      cyl = START_CYL[7:0];
      step_q = 1'b0;
   end

   // The head moves once per rising step edge; it cannot pass track zero.
   always @(posedge mclk) begin
      step_q <= drv.step;
      if (drv.step && !step_q) begin
         if (drv.dir) begin
            cyl <= cyl + 8'h01;
         end else if (cyl != 8'h00) begin
            cyl <= cyl - 8'h01;
         end
      end
   end

   assign track0 = (cyl == 8'h00);
endmodule

//--- verilog/fdcws_core.sv
// Command sequencer for write, format, seek and housekeeping commands.
`timescale 1ns/1ns
`include "fdcws_regs.svh"

// Function
// RULE1 - Version command answers one byte 0x90.
// RULE2 - Write data decoded, bytes forwarded to drive.
// RULE3 - Drive byte carries head and drive select.
// RULE4 - Write takes seven parameters after drive byte.
// RULE5 - Write results: three status bytes, then CHRN.
// RULE6 - Write deleted behaves as write, deleted mark.
// RULE7 - Format takes four parameters, returns seven bytes.
// RULE8 - Format takes four identifier bytes per sector.
// RULE9 - Recalibrate steps to track zero, then interrupts.
// RULE10 - Sense interrupt returns status zero and cylinder.
// RULE11 - Specify stores step, unload, load, no-DMA.
// RULE12 - Seek steps head to the new cylinder.
// RULE13 - Bytes pass singly; results drained before next.
// RULE14 - Sense interrupt clears the pending seek interrupt.
module fdcws_core #(
   parameter int STEP_UNIT_CYC = `FDCWS_STEP_UNIT_NS / `FDCWS_CLK_NS
) (
   input  wire logic                 mclk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   input  wire logic                 host_wr,
   input  wire logic [7:0]           host_wdata,
   input  wire logic                 host_rd,
   output logic [7:0]                host_rdata,
   output logic                      result_ready,
   output logic                      cmd_busy,
   output logic                      exec_data_req,
   output logic                      fdc_interrupt,
   output fdcws_pkg::fdcws_spec_t    spec_cfg,
   output fdcws_pkg::fdcws_drive_t   disk_drive,
   input  wire logic                 disk_track0
);

   // ****************************************************************
   // Parameter check and decode
   // ****************************************************************
   if (STEP_UNIT_CYC < 1) begin : g_bad_unit
      $error("STEP_UNIT_CYC must be at least one cycle.");
   end

   function automatic fdcws_pkg::fdcws_cmd_t decode(input logic [7:0] b);
      logic [7:0] rw;
      logic [7:0] fm;
      rw = b & `FDCWS_MASK_RW;
      fm = b & `FDCWS_MASK_FMT;
      if (b == `FDCWS_OP_VERSION)   return fdcws_pkg::CMD_VERSION;
      if (rw == `FDCWS_OP_WRITE)    return fdcws_pkg::CMD_WRITE;
      if (rw == `FDCWS_OP_WRITE_DEL) return fdcws_pkg::CMD_WRITE_DEL;
      if (fm == `FDCWS_OP_FORMAT)   return fdcws_pkg::CMD_FORMAT;
      if (b == `FDCWS_OP_RECAL)     return fdcws_pkg::CMD_RECAL;
      if (b == `FDCWS_OP_SENSE)     return fdcws_pkg::CMD_SENSE;
      if (b == `FDCWS_OP_SPECIFY)   return fdcws_pkg::CMD_SPECIFY;
      if (b == `FDCWS_OP_SEEK)      return fdcws_pkg::CMD_SEEK;
      return fdcws_pkg::CMD_NONE;
   endfunction

   function automatic logic [3:0] param_count(input fdcws_pkg::fdcws_cmd_t c);
      case (c)
         fdcws_pkg::CMD_WRITE,
         fdcws_pkg::CMD_WRITE_DEL: param_count = 4'd8; // RULE4
         fdcws_pkg::CMD_FORMAT:    param_count = 4'd5; // RULE7
         fdcws_pkg::CMD_RECAL:     param_count = 4'd1; // RULE9
         fdcws_pkg::CMD_SPECIFY:   param_count = 4'd2; // RULE11
         fdcws_pkg::CMD_SEEK:      param_count = 4'd2; // RULE12
         default:                  param_count = 4'd0;
      endcase
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   fdcws_pkg::fdcws_state_t state;
   fdcws_pkg::fdcws_cmd_t   cmd;
   logic [7:0]  cmd_byte;
   logic [7:0]  prm [0:7];
   logic [3:0]  pcnt;
   logic [7:0]  res [0:6];
   logic [2:0]  nres;
   logic [2:0]  ridx;
   logic [7:0]  cyl_tab [0:3];
   logic [7:0]  cyl;
   logic        head;
   logic [7:0]  sec;
   logic [7:0]  scnt;
   logic [14:0] bcnt;
   logic [7:0]  status_seek;
   logic        step_start;
   logic        step_done;
   logic        step_fail;
   logic        step_pulse;
   logic        step_dir;
   logic [7:0]  step_cyl;

   // ****************************************************************
   // Continuous decode
   // ****************************************************************
   wire         is_fmt     = (cmd == fdcws_pkg::CMD_FORMAT);
   wire         multitrack = cmd_byte[`FDCWS_BIT_MULTI];
   wire [1:0]   ds         = prm[0][1:0]; // RULE3
   wire         head_sel   = prm[0][`FDCWS_BIT_HEAD]; // RULE3
   wire [2:0]   ncode      = (prm[4] > 8'h07) ? 3'h7 : prm[4][2:0];
   wire [14:0]  sect_bytes = (prm[4] == 8'h00) ? {7'h00, prm[7]}
                             : 15'(`FDCWS_SECT_BASE << ncode);
   wire [14:0]  unit_bytes = is_fmt ? `FDCWS_FMT_ID_BYTES : sect_bytes;
   wire         exec_take  = (state == fdcws_pkg::ST_EXEC) && host_wr;
   wire         unit_end   = exec_take && (bcnt == 15'h0001);
   wire         last_unit  = is_fmt ? (scnt <= 8'h01)
                             : (sec == prm[5] && (!multitrack || head));
   wire         rd_take    = result_ready && host_rd;
   wire [7:0]   status_now = {5'h00, head, ds};
   wire         seek_cmd   = (cmd == fdcws_pkg::CMD_SEEK);

   // ****************************************************************
   // Head stepper
   // ****************************************************************
   fdcws_stepper #(
      .STEP_UNIT_CYC (STEP_UNIT_CYC)
   ) u_stepper (
      .mclk      (mclk),
      .nrst      (nrst),
      .ce        (ce),
      .start     (step_start),
      .recal     (!seek_cmd),
      .target    (prm[1]),
      .cur       (cyl_tab[ds]),
      .step_rate (spec_cfg.step_rate),
      .track0    (disk_track0),
      .step      (step_pulse),
      .dir       (step_dir),
      .done      (step_done),
      .fail      (step_fail),
      .cyl_now   (step_cyl)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state         <= fdcws_pkg::ST_IDLE;
         cmd           <= fdcws_pkg::CMD_NONE;
         cmd_byte      <= 8'h00;
         pcnt          <= 4'h0;
         nres          <= 3'h0;
         ridx          <= 3'h0;
         cyl           <= 8'h00;
         head          <= 1'b0;
         sec           <= 8'h00;
         scnt          <= 8'h00;
         bcnt          <= 15'h0000;
         status_seek   <= 8'h00;
         step_start    <= 1'b0;
         host_rdata    <= 8'h00;
         result_ready  <= 1'b0;
         cmd_busy      <= 1'b0;
         exec_data_req <= 1'b0;
         fdc_interrupt <= 1'b0;
         spec_cfg      <= `FDCWS_RESET_SPEC;
         disk_drive    <= '0;
         for (int i = 0; i < 8; i++) prm[i] <= 8'h00;
         for (int i = 0; i < 7; i++) res[i] <= 8'h00;
         for (int i = 0; i < 4; i++) cyl_tab[i] <= 8'h00;
      end else if (ce) begin
         step_start           <= 1'b0;
         disk_drive.wr_strobe <= 1'b0;
         disk_drive.step      <= step_pulse;
         disk_drive.dir       <= step_dir;
         host_rdata           <= res[ridx];
         result_ready         <= (state == fdcws_pkg::ST_RESULT) && !rd_take;
         cmd_busy             <= (state != fdcws_pkg::ST_IDLE);
         exec_data_req        <= (state == fdcws_pkg::ST_EXEC) && !unit_end;
         case (state)
            fdcws_pkg::ST_IDLE: begin
               if (host_wr) begin // RULE13
                  cmd      <= decode(host_wdata);
                  cmd_byte <= host_wdata;
                  pcnt     <= 4'h0;
                  if (decode(host_wdata) == fdcws_pkg::CMD_NONE)
                     state <= fdcws_pkg::ST_IDLE;
                  else if (param_count(decode(host_wdata)) == 4'h0)
                     state <= fdcws_pkg::ST_GO;
                  else
                     state <= fdcws_pkg::ST_PARAM;
               end
            end
            fdcws_pkg::ST_PARAM: begin
               if (host_wr) begin
                  prm[pcnt[2:0]] <= host_wdata;
                  pcnt           <= pcnt + 4'h1;
                  if (pcnt + 4'h1 == param_count(cmd))
                     state <= fdcws_pkg::ST_GO;
               end
            end
            fdcws_pkg::ST_GO: begin
               ridx  <= 3'h0;
               state <= fdcws_pkg::ST_RESULT;
               case (cmd)
                  fdcws_pkg::CMD_VERSION: begin
                     res[0] <= `FDCWS_VERSION_RESULT; // RULE1
                     nres   <= 3'h1;
                  end
                  fdcws_pkg::CMD_SENSE: begin
                     // Without a pending seek the answer is the invalid code.
                     res[0] <= fdc_interrupt ? status_seek
                               : `FDCWS_STAT_INVALID; // RULE10
                     res[1] <= cyl_tab[status_seek[1:0]]; // RULE10
                     nres   <= fdc_interrupt ? 3'h2 : 3'h1;
                     fdc_interrupt <= 1'b0; // RULE14
                  end
                  fdcws_pkg::CMD_SPECIFY: begin
                     spec_cfg <= {prm[0], prm[1]}; // RULE11
                     state    <= fdcws_pkg::ST_IDLE;
                  end
                  fdcws_pkg::CMD_SEEK,
                  fdcws_pkg::CMD_RECAL: begin
                     disk_drive.drive_select     <= ds;
                     disk_drive.head_side_select <= seek_cmd && head_sel;
                     step_start <= 1'b1; // RULE12
                     state      <= fdcws_pkg::ST_SEEK;
                  end
                  fdcws_pkg::CMD_WRITE,
                  fdcws_pkg::CMD_WRITE_DEL,
                  fdcws_pkg::CMD_FORMAT: begin
                     disk_drive.drive_select     <= ds;
                     disk_drive.head_side_select <= prm[0][`FDCWS_BIT_HEAD];
                     disk_drive.deleted_mark <=
                        (cmd == fdcws_pkg::CMD_WRITE_DEL); // RULE6
                     cyl   <= prm[1];
                     head  <= is_fmt ? prm[0][`FDCWS_BIT_HEAD] : prm[2][0];
                     sec   <= prm[3];
                     scnt  <= prm[2];
                     bcnt  <= unit_bytes;
                     state <= fdcws_pkg::ST_EXEC;
                  end
                  default: state <= fdcws_pkg::ST_IDLE;
               endcase
            end
            fdcws_pkg::ST_EXEC: begin
               if (exec_take) begin
                  disk_drive.wr_strobe <= 1'b1; // RULE2
                  disk_drive.wr_byte   <= host_wdata; // RULE8
                  bcnt                 <= bcnt - 15'h0001;
               end
               if (unit_end) begin
                  bcnt <= unit_bytes;
                  scnt <= scnt - 8'h01;
                  if (!is_fmt && sec == prm[5] && multitrack && !head) begin
                     head <= 1'b1;
                     sec  <= 8'h01;
                     disk_drive.head_side_select <= 1'b1;
                  end else if (!is_fmt) begin
                     sec <= sec + 8'h01;
                  end
                  if (last_unit) begin
                     res[0] <= status_now; // RULE5
                     res[1] <= `FDCWS_ZERO_BYTE;
                     res[2] <= `FDCWS_ZERO_BYTE;
                     // Format leaves the last four bytes undefined; zero here.
                     res[3] <= is_fmt ? `FDCWS_ZERO_BYTE
                               : multitrack ? cyl + 8'h01 : cyl; // RULE7
                     res[4] <= is_fmt ? `FDCWS_ZERO_BYTE : {7'h00, head};
                     res[5] <= is_fmt ? `FDCWS_ZERO_BYTE : 8'h01;
                     res[6] <= is_fmt ? `FDCWS_ZERO_BYTE : prm[4];
                     if (!is_fmt && !multitrack)
                        res[5] <= sec + 8'h01;
                     nres  <= 3'h7; // RULE5
                     ridx  <= 3'h0;
                     state <= fdcws_pkg::ST_RESULT;
                  end
               end
            end
            fdcws_pkg::ST_SEEK: begin
               if (step_done) begin
                  cyl_tab[ds]   <= step_cyl;
                  status_seek   <= {2'b00, 1'b1, step_fail, 1'b0,
                                    disk_drive.head_side_select, ds};
                  fdc_interrupt <= 1'b1; // RULE9
                  state         <= fdcws_pkg::ST_IDLE;
               end
            end
            fdcws_pkg::ST_RESULT: begin
               if (rd_take) begin // RULE13
                  ridx <= ridx + 3'h1;
                  if (ridx + 3'h1 == nres)
                     state <= fdcws_pkg::ST_IDLE;
               end
            end
            default: state <= fdcws_pkg::ST_IDLE;
         endcase
      end
   end

endmodule

//--- verilog/fdcws_pkg.sv
// Types shared by the command sequencer, the drive model and the checks.
package fdcws_pkg;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_VERSION, CMD_WRITE, CMD_WRITE_DEL, CMD_FORMAT,
      CMD_RECAL, CMD_SENSE, CMD_SPECIFY, CMD_SEEK
   } fdcws_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_PARAM, ST_GO, ST_EXEC, ST_SEEK, ST_RESULT
   } fdcws_state_t;

   typedef struct packed {
      logic [3:0] step_rate;
      logic [3:0] head_unload_time;
      logic [6:0] head_load_time;
      logic       no_dma_flag;
   } fdcws_spec_t;

   typedef struct packed {
      logic [1:0] drive_select;
      logic       head_side_select;
      logic       step;
      logic       dir;
      logic       wr_strobe;
      logic       deleted_mark;
      logic [7:0] wr_byte;
   } fdcws_drive_t;

endpackage

//--- verilog/fdcws_regs.svh
// Command codes, field positions, reset values and timing counts.
`ifndef FDCWS_REGS_SVH
`define FDCWS_REGS_SVH

// ****************************************************************
// Command bytes and decode masks
// ****************************************************************
`define FDCWS_OP_VERSION     8'h10
`define FDCWS_OP_WRITE       8'h05
`define FDCWS_OP_WRITE_DEL   8'h09
`define FDCWS_OP_FORMAT      8'h0d
`define FDCWS_OP_RECAL       8'h07
`define FDCWS_OP_SENSE       8'h08
`define FDCWS_OP_SPECIFY     8'h03
`define FDCWS_OP_SEEK        8'h0f
`define FDCWS_MASK_RW        8'h3f
`define FDCWS_MASK_FMT       8'hbf

// ****************************************************************
// Field positions
// ****************************************************************
`define FDCWS_BIT_MULTI      7
`define FDCWS_BIT_DD         6
`define FDCWS_BIT_HEAD       2
`define FDCWS_STAT_SEEK_END  5
`define FDCWS_STAT_EQUIP_CHK 4

// ****************************************************************
// Result values and reset values
// ****************************************************************
`define FDCWS_VERSION_RESULT 8'h90
`define FDCWS_STAT_INVALID   8'h80
`define FDCWS_ZERO_BYTE      8'h00
`define FDCWS_FMT_ID_BYTES   15'h0004
`define FDCWS_SECT_BASE      16'h0080
`define FDCWS_RESET_SPEC     16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define FDCWS_CLK_NS         100
`define FDCWS_STEP_UNIT_NS   1000000
`define FDCWS_STEP_PULSE_NS  1000
`define FDCWS_STEP_PULSE_CYC \
   ((`FDCWS_STEP_PULSE_NS + `FDCWS_CLK_NS - 1) / `FDCWS_CLK_NS)
`define FDCWS_RECAL_MAX      79

`endif

//--- verilog/fdcws_stepper.sv
// Head stepper for seek and recalibrate.
`timescale 1ns/1ns
`include "fdcws_regs.svh"
module fdcws_stepper #(
   parameter int STEP_UNIT_CYC = 10000
) (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       ce,
   input  wire logic       start,
   input  wire logic       recal,
   input  wire logic [7:0] target,
   input  wire logic [7:0] cur,
   input  wire logic [3:0] step_rate,
   input  wire logic       track0,
   output logic            step,
   output logic            dir,
   output logic            done,
   output logic            fail,
   output logic [7:0]      cyl_now
);

   localparam int TW = 32;

   logic          busy;
   logic          mode_recal;
   logic [7:0]    goal;
   logic [7:0]    nsteps;
   logic [TW-1:0] timer;

   // Slower rate codes give longer gaps; code 0 is the slowest.
   wire [TW-1:0] period = TW'((5'd16 - {1'b0, step_rate})
                              * STEP_UNIT_CYC);
   wire          at_goal = mode_recal ? track0 : (cyl_now == goal);
   wire          gave_up = mode_recal && (nsteps == 8'(`FDCWS_RECAL_MAX));

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         busy       <= 1'b0;
         mode_recal <= 1'b0;
         goal       <= 8'h00;
         nsteps     <= 8'h00;
         timer      <= '0;
         step       <= 1'b0;
         dir        <= 1'b0;
         done       <= 1'b0;
         fail       <= 1'b0;
         cyl_now    <= 8'h00;
      end else if (ce) begin
         done <= 1'b0;
         // The pulse keeps its fixed width; the step rate sets the gap.
         if (timer == period + TW'(1))
            step <= 1'b0;
         if (start) begin
            busy       <= 1'b1;
            mode_recal <= recal;
            goal       <= target;
            nsteps     <= 8'h00;
            cyl_now    <= cur;
            timer      <= '0;
            fail       <= 1'b0;
         end else if (busy) begin
            if (timer != '0) begin
               timer <= timer - 1'b1;
            end else if (at_goal || gave_up) begin
               busy <= 1'b0;
               done <= 1'b1;
               fail <= gave_up && !track0;
               if (mode_recal)
                  cyl_now <= 8'h00; // RULE9
            end else begin
               // Direction high means stepping inward.
               dir    <= !mode_recal && (goal > cyl_now); // RULE12
               step   <= 1'b1;
               timer  <= period + TW'(`FDCWS_STEP_PULSE_CYC);
               nsteps <= nsteps + 8'h01;
               if (mode_recal || goal < cyl_now)
                  cyl_now <= cyl_now - 8'h01;
               else
                  cyl_now <= cyl_now + 8'h01;
            end
         end
      end
   end

endmodule
